// [include/srx_pkg.sv]
package srx_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ     = 25;
   localparam int PRE_TMO_US  = 100;                  // No preamble at all
   localparam int PRE_TMO_CYC = PRE_TMO_US * CLK_MHZ; // Longest time, floor

   // ----------------------------------------------------------------
   // Register map (byte addresses) and control fields
   // ----------------------------------------------------------------
   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_STAT  = 8'h04;
   localparam logic [7:0] A_CS    = 8'h08;
   localparam logic [7:0] A_FSPER = 8'h0C;
   localparam int C_RANGE = 0;   // 2 bits, fs_flag_range_select
   localparam int C_SRC   = 2;   // flag_pin_source_select, 1 = emphasis
   localparam int C_NPERR = 3;   // nonpcm_error_select
   localparam int C_HOLD  = 4;   // 2 bits, error_hold_time
   localparam int C_PFMT  = 6;   // parity_flag_format
   localparam int C_TOL   = 7;   // fs_change_tolerance
   localparam int C_COMB  = 8;   // indicator_combine_select
   localparam int C_NPIRQ = 9;   // nonpcm_interrupt_source
   localparam int C_AUTO  = 10;  // Oscillator auto-stop mode
   localparam int CTRL_W  = 11;
   localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;

   // ----------------------------------------------------------------
   // Stream constants
   // ----------------------------------------------------------------
   localparam int CS_AUDIO = 1;
   localparam int CS_EMPH  = 3;   // 3 bits
   localparam int CS_FS    = 24;  // 4 bits
   localparam logic [2:0]  EMPH_5015    = 3'h1;
   localparam logic [7:0]  BLOCK_FRAMES = 8'hC0;   // 192
   localparam logic [3:0]  RUN_LONG     = 4'h9;
   localparam logic [11:0] DTS_LAST     = 12'hFFF; // Every 4096th frame
   localparam logic [15:0] IEC_PA = 16'hF872;
   localparam logic [15:0] IEC_PB = 16'h4E1F;
   localparam logic [15:0] DTS_W0 = 16'h1FFF;
   localparam logic [15:0] DTS_W1 = 16'hE800;

   // ----------------------------------------------------------------
   // Frame period bounds in crystal cycles, and fs codes
   // ----------------------------------------------------------------
   localparam logic [11:0] P_MAX = 12'h384;   // 900
   localparam logic [11:0] P_32  = 12'h2A2;   // 674
   localparam logic [11:0] P_44  = 12'h220;   // 544
   localparam logic [11:0] P_48  = 12'h192;   // 402
   localparam logic [11:0] P_88  = 12'h110;   // 272
   localparam logic [11:0] P_96  = 12'h0C8;   // 200
   localparam logic [11:0] P_176 = 12'h087;   // 135
   localparam logic [11:0] P_192 = 12'h06E;   // 110

   typedef enum logic [2:0] {
      FS_NONE, FS_32, FS_44, FS_48, FS_88, FS_96, FS_176, FS_192
   } srx_fs_e;

   typedef enum logic [1:0] {
      ST_OK = 2'b00, ST_ERR = 2'b01, ST_HOLD = 2'b11
   } srx_flag_e;

   function automatic srx_fs_e srx_classify(input logic [11:0] p);
      if (p >= P_MAX)      return FS_NONE;
      else if (p >= P_32)  return FS_32;
      else if (p >= P_44)  return FS_44;
      else if (p >= P_48)  return FS_48;
      else if (p >= P_88)  return FS_88;
      else if (p >= P_96)  return FS_96;
      else if (p >= P_176) return FS_176;
      else if (p >= P_192) return FS_192;
      else                 return FS_NONE;
   endfunction

   function automatic logic srx_range_hit(input logic [1:0] sel,
                                          input srx_fs_e    c);
      case (sel)
         2'b00:   return c == FS_32 || c == FS_44 || c == FS_48;
         2'b01:   return c == FS_88 || c == FS_96;
         2'b10:   return c == FS_176 || c == FS_192;
         default: return c >= FS_88;
      endcase
   endfunction

endpackage

// [design/srx_error_flags.sv]
`timescale 1ns/100ps
// What this block does
// - Measure fs on crystal clock; auto mode only during error, else always.
// - fs flag pin high per 2-bit range select of measured rate.
// - Error flag high whenever lock error or data error present.
// - Lose lock on bi-phase fault, missing preambles, or blocks not 192.
// - After errors clear, keep flag high for selectable 3 to 144 ms.
// - Error flag moves on frame word clock edges; a compare hit raises it at once.
// - Nine or more consecutive parity errors raise flag, then hold time.
// - Short parity runs show on the flag per the parity format bit.
// - While flag low, block-to-block cs fs bits or fs change raises error.
// - Tolerance option ignores in-range fs change and skips cs compare.
// - Non-PCM-as-error option raises flag and mutes output data.
// - Short parity runs on PCM repeat previous same-channel sample.
// - PCM judgement uses cs bit 1 captured before the parity error.
// - Output data forced low on lock error or long parity run.
// - cs bits held on short runs, cleared on errors; fs cleared on unlock.
// - Output resumes at first frame clock edge after flag falls.
// - Indicator pin shows cs bit 1 at once, even during error.
// - Combine select ORs burst sync flags onto the indicator pin.
// - Source select puts emphasis state on the fs flag pin at once.
// - IEC burst sync flag searched and shown only for non-PCM streams; DTS for any.
// - 14-bit sync checked each 4096th frame with base rate, held.
// - Interrupt pin low on sync detect; flags cleared on fs or errors.
module srx_error_flags
   import srx_pkg::*;
#(
   parameter int HOLD0_US = 3000,
   parameter int HOLD1_US = 24000,
   parameter int HOLD2_US = 72000,
   parameter int HOLD3_US = 144000
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        frame_word_clock,
   input  wire logic        sf_valid,
   input  wire logic        sf_left,
   input  wire logic        sf_block,
   input  wire logic [23:0] sf_data,
   input  wire logic        sf_parity_err,
   input  wire logic        sf_cs_bit,
   input  wire logic        biphase_err,
   output logic             fs_flag_pin,
   output logic             error_flag_pin,
   output logic             indicator_pin,
   output logic             irq_n,
   output logic             out_valid,
   output logic             out_left,
   output logic [23:0]      out_data
);

   localparam logic [21:0] HOLD0_CYC = 22'(HOLD0_US * CLK_MHZ);
   localparam logic [21:0] HOLD1_CYC = 22'(HOLD1_US * CLK_MHZ);
   localparam logic [21:0] HOLD2_CYC = 22'(HOLD2_US * CLK_MHZ);
   localparam logic [21:0] HOLD3_CYC = 22'(HOLD3_US * CLK_MHZ);

   logic [CTRL_W-1:0] ctrl;
   logic [1:0]        fwc_sync;
   logic              fwc_last, fwc_rise;
   logic [7:0]        blk_frames;
   logic [4:0]        cs_idx;
   logic [11:0]       tmo_cnt;
   logic              lock_err, cmp_hit, data_err, short_err;
   logic [3:0]        run, next_run;
   logic [31:0]       cs;
   logic              nonpcm, emph, mute, err_src, out_en;
   logic [11:0]       per_cnt, fs_period;
   srx_fs_e           fs_code, blk_fs, meas;
   logic [3:0]        blk_csfs;
   logic              measure_en, fs_chg, clr_det;
   srx_flag_e         st, next_st;
   logic [21:0]       hold_cnt, hold_load;
   logic              err_q;
   logic [23:0]       prev [2];
   logic [15:0]       last_word;
   logic              iec_flag, dts_flag, dts_seen;
   logic [11:0]       dts_frames;
   logic              wr_pend;
   logic [7:0]        wr_addr;

   // ----------------------------------------------------------------
   // Frame word clock synchroniser and edge finder
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fwc_sync <= 2'b00;
         fwc_last <= 1'b0;
      end else begin
         fwc_sync <= {fwc_sync[0], frame_word_clock};
         fwc_last <= fwc_sync[1];
      end
   end
   assign fwc_rise = fwc_sync[1] & ~fwc_last;

   // ----------------------------------------------------------------
   // Lock supervision
   // ----------------------------------------------------------------
   // Block length is measured between two B preambles, so lock returns at the
   // first B that closes a 192-frame block, even one begun before the fault
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         blk_frames <= 8'h00;
         tmo_cnt    <= 12'h000;
         lock_err   <= 1'b1;
      end else begin
         if (sf_valid && sf_block)
            blk_frames <= 8'h00;
         else if (sf_valid && !sf_left)
            blk_frames <= blk_frames + 8'h01;
         if (sf_valid)
            tmo_cnt <= 12'h000;
         else if (tmo_cnt != 12'(PRE_TMO_CYC))
            tmo_cnt <= tmo_cnt + 12'h001;
         if (biphase_err || tmo_cnt == 12'(PRE_TMO_CYC) || cmp_hit ||
             (sf_valid && sf_block && blk_frames != BLOCK_FRAMES))
            lock_err <= 1'b1;
         else if (sf_valid && sf_block)
            lock_err <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Parity run counter
   // ----------------------------------------------------------------
   always_comb begin
      if (!sf_parity_err)
         next_run = 4'h0;
      else if (run == 4'hF)
         next_run = run;
      else
         next_run = run + 4'h1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         run <= 4'h0;
      else if (sf_valid)
         run <= next_run;
   end
   assign data_err  = run >= RUN_LONG;
   assign short_err = run != 4'h0 && run < RUN_LONG;

   // ----------------------------------------------------------------
   // Channel status capture, left subframes only
   // ----------------------------------------------------------------
   assign cs_idx = sf_block ? 5'h00 : blk_frames[4:0];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         cs <= 32'h0000_0000;
      else if (lock_err || data_err)
         cs <= 32'h0000_0000;
      else if (sf_valid && sf_left && !sf_parity_err &&
               (sf_block || blk_frames < 8'h20))
         cs[cs_idx] <= sf_cs_bit;
   end
   // Held bits keep the pre-error value, so this is the earlier bit 1
   assign nonpcm = cs[CS_AUDIO];
   assign emph   = cs[CS_EMPH +: 3] == EMPH_5015;

   // ----------------------------------------------------------------
   // Sampling frequency measurement, one frame period per sample
   // ----------------------------------------------------------------
   assign measure_en = !ctrl[C_AUTO] || (err_q && !lock_err);
   assign meas       = srx_classify(per_cnt);
   assign fs_chg     = fwc_rise && measure_en && !lock_err &&
                       meas != fs_code;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         per_cnt   <= 12'h000;
         fs_period <= 12'h000;
         fs_code   <= FS_NONE;
      end else begin
         if (fwc_rise)
            per_cnt <= 12'h001;
         else if (per_cnt != 12'hFFF)
            per_cnt <= per_cnt + 12'h001;
         if (lock_err)
            fs_code <= FS_NONE;
         else if (fwc_rise && measure_en) begin
            fs_code   <= meas;
            fs_period <= per_cnt;
         end
      end
   end

   // ----------------------------------------------------------------
   // Block-to-block comparison
   // ----------------------------------------------------------------
   assign cmp_hit = sf_valid && sf_block && !err_q &&
      ((!ctrl[C_TOL] && cs[CS_FS +: 4] != blk_csfs) ||
       ((!ctrl[C_TOL] || fs_code == FS_NONE) && fs_code != blk_fs));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         blk_csfs <= 4'h0;
         blk_fs   <= FS_NONE;
      end else if (sf_valid && sf_block) begin
         blk_csfs <= cs[CS_FS +: 4];
         blk_fs   <= fs_code;
      end
   end

   // ----------------------------------------------------------------
   // Error flag state machine
   // ----------------------------------------------------------------
   assign err_src = lock_err || data_err ||
                    (ctrl[C_NPERR] && nonpcm) ||
                    (ctrl[C_PFMT] && short_err);

   always_comb begin
      case (ctrl[C_HOLD +: 2])
         2'b00:   hold_load = HOLD0_CYC;
         2'b01:   hold_load = HOLD1_CYC;
         2'b10:   hold_load = HOLD2_CYC;
         default: hold_load = HOLD3_CYC;
      endcase
   end

   always_comb begin
      case (st)
         ST_OK:   next_st = err_src ? ST_ERR : ST_OK;
         ST_ERR:  next_st = err_src ? ST_ERR : ST_HOLD;
         ST_HOLD: begin
            if (err_src)
               next_st = ST_ERR;
            else if (hold_cnt == 22'h0)
               next_st = ST_OK;
            else
               next_st = ST_HOLD;
         end
         default: next_st = ST_ERR;
      endcase
   end

   // Only the compare hit bypasses the frame clock: it must show at once
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st       <= ST_ERR;
         hold_cnt <= 22'h0;
         err_q    <= 1'b1;
      end else begin
         if (st == ST_HOLD && hold_cnt != 22'h0)
            hold_cnt <= hold_cnt - 22'h1;
         if (fwc_rise) begin
            st <= next_st;
            if (st == ST_ERR && next_st == ST_HOLD)
               hold_cnt <= hold_load;
         end
         if (cmp_hit)
            err_q <= 1'b1;
         else if (fwc_rise)
            err_q <= next_st != ST_OK;
      end
   end
   assign error_flag_pin = err_q;

   // Output gate reopens one frame clock edge after the flag falls
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         out_en <= 1'b0;
      else if (err_q)
         out_en <= 1'b0;
      else if (fwc_rise)
         out_en <= 1'b1;
   end

   // ----------------------------------------------------------------
   // Data path: mute, substitution, pass-through
   // ----------------------------------------------------------------
   assign mute = lock_err || next_run >= RUN_LONG ||
                 !out_en || (ctrl[C_NPERR] && nonpcm);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_valid <= 1'b0;
         out_left  <= 1'b0;
         out_data  <= 24'h0;
         for (int i = 0; i < 2; i++)
            prev[i] <= 24'h0;
      end else begin
         out_valid <= sf_valid;
         if (sf_valid) begin
            out_left <= sf_left;
            if (mute)
               out_data <= 24'h0;
            else if (sf_parity_err && !nonpcm)
               out_data <= prev[sf_left];
            else
               out_data <= sf_data;
            if (!sf_parity_err)
               prev[sf_left] <= sf_data;
         end
      end
   end

   // ----------------------------------------------------------------
   // Compressed audio sync detection
   // ----------------------------------------------------------------
   assign clr_det = fs_chg || lock_err || data_err;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_word  <= 16'h0;
         iec_flag   <= 1'b0;
         dts_flag   <= 1'b0;
         dts_seen   <= 1'b0;
         dts_frames <= 12'h000;
      end else begin
         if (sf_valid)
            last_word <= sf_data[23:8];
         if (clr_det || !nonpcm)
            iec_flag <= 1'b0;
         else if (sf_valid && last_word == IEC_PA &&
                  sf_data[23:8] == IEC_PB)
            iec_flag <= 1'b1;
         if (sf_valid && !sf_left)
            dts_frames <= dts_frames + 12'h001;
         // A sighting inside the period is held only until the period boundary
         if (clr_det) begin
            dts_flag <= 1'b0;
            dts_seen <= 1'b0;
         end else if (sf_valid && !sf_left && dts_frames == DTS_LAST) begin
            // A sighting in the last frame of a period still counts
            dts_flag <= (dts_seen || (last_word == DTS_W0 &&
                         sf_data[23:8] == DTS_W1)) &&
                        (fs_code == FS_44 || fs_code == FS_48);
            dts_seen <= 1'b0;
         end else if (sf_valid && last_word == DTS_W0 &&
                      sf_data[23:8] == DTS_W1)
            dts_seen <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Flag pins: immediate, independent of the error flag
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fs_flag_pin   <= 1'b0;
         indicator_pin <= 1'b0;
         irq_n         <= 1'b1;
      end else begin
         fs_flag_pin <= ctrl[C_SRC] ? emph :
                        srx_range_hit(ctrl[C_RANGE +: 2], fs_code);
         indicator_pin <= nonpcm ||
                          (ctrl[C_COMB] && (iec_flag || dts_flag));
         irq_n <= !(ctrl[C_NPIRQ] && (iec_flag || dts_flag));
      end
   end

   // ----------------------------------------------------------------
   // AHB-Lite slave: zero wait states, always OKAY
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata  <= 32'h0;
      end else begin
         wr_pend <= 1'b0;
         if (hsel && htrans[1] && hready && hsize == 3'b010) begin
            if (hwrite) begin
               wr_pend <= 1'b1;
               wr_addr <= haddr[7:0];
            end else begin
               case (haddr[7:0])
                  A_CTRL:  hrdata <= {21'h0, ctrl};
                  A_STAT:  hrdata <= {21'h0, fs_code, out_en, dts_flag,
                                      iec_flag, emph, nonpcm, data_err,
                                      lock_err, err_q};
                  A_CS:    hrdata <= cs;
                  A_FSPER: hrdata <= {20'h0, fs_period};
                  default: hrdata <= 32'h0;
               endcase
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         ctrl <= CTRL_RST;
      else if (wr_pend && wr_addr == A_CTRL)
         ctrl <= hwdata[CTRL_W-1:0];
   end
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_recover;
      fwc_rise && st == ST_ERR && !err_src;
   endsequence

   AST_ERR_SRC: assert property (
      (fwc_rise && (lock_err || data_err)) |=> error_flag_pin)
      else $error("error flag low with error present");
   AST_FLAG_SYNC: assert property (
      $changed(err_q) |-> $past(fwc_rise) || $past(cmp_hit))
      else $error("error flag moved off frame clock edge");
   AST_BLOCK_LEN: assert property (
      (sf_valid && sf_block && blk_frames != BLOCK_FRAMES) |=> lock_err)
      else $error("bad block length kept lock");
   AST_LONG_RUN: assert property (
      (sf_valid && sf_parity_err && run == 4'h8) |=> data_err)
      else $error("ninth parity error not flagged");
   AST_HOLD: assert property (
      s_recover |=> st == ST_HOLD && hold_cnt == $past(hold_load))
      else $error("hold time not loaded on recovery");
   AST_MUTE: assert property (
      (sf_valid && lock_err) |=> out_valid && out_data == 24'h0)
      else $error("data not muted on lock error");
   AST_SUBST: assert property (
      (sf_valid && sf_left && sf_parity_err && !nonpcm && !mute)
      |=> out_data == $past(prev[1]))
      else $error("previous sample not repeated");
   AST_PCM_PIN: assert property (
      !$past(ctrl[C_COMB]) |-> indicator_pin == $past(nonpcm))
      else $error("indicator pin not following cs bit 1");
   AST_CLR_DET: assert property (
      lock_err |=> !iec_flag && !dts_flag)
      else $error("sync flags survived lock error");
   AST_IRQ: assert property (
      (ctrl[C_NPIRQ] && iec_flag) |=> !irq_n)
      else $error("interrupt not raised on burst sync");
   AST_RESUME: assert property (
      $rose(out_en) |-> $past(fwc_rise) && !$past(err_q))
      else $error("output resumed off frame clock edge");

endmodule // srx_error_flags

// [dv/srx_tx_model.sv]
`timescale 1ns/100ps
// Far-side transmitter; frame clock high during the left subframe
module srx_tx_model (
   input  wire logic        hclk,
   output logic             frame_word_clock,
   output logic             sf_valid,
   output logic             sf_left,
   output logic             sf_block,
   output logic [23:0]      sf_data,
   output logic             sf_parity_err,
   output logic             sf_cs_bit
);
   // Idle at time zero; cs bit low keeps the stream PCM
   initial begin
      {frame_word_clock, sf_valid, sf_left, sf_block, sf_parity_err} = '0;
      sf_data = 24'h000000;
      sf_cs_bit = 1'b0;
   end
   // Four clocks a subframe give the 320 ns frame clock
   task automatic sub(input logic l, input logic b, input logic p,
                      input logic c, input logic [23:0] d);
      frame_word_clock <= l;
      {sf_valid, sf_left, sf_block, sf_parity_err} <= {1'b1, l, b, p};
      sf_cs_bit <= c;
      sf_data <= d;
      @(posedge hclk);
      sf_valid <= 1'b0;
      sf_data <= ~d;  // Stale word inverted so it is never trusted
      repeat (3) @(posedge hclk);
   endtask
endmodule // srx_tx_model

// [dv/tb_srx_error_flags.sv]
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
   cmp_count++; \
   if ((g) !== (e)) begin \
      fails++; \
      $display("ERROR %s expected %0h seen %0h", nm, e, g); \
   end \
end
module tb_srx_error_flags
   import srx_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, biphase_err;
   logic        frame_word_clock, sf_valid, sf_left, sf_block, sf_cs_bit;
   logic        sf_parity_err, fs_flag_pin, error_flag_pin, indicator_pin;
   logic        irq_n, out_valid, out_left;
   logic [1:0]  htrans;
   logic [23:0] sf_data, out_data;
   logic [31:0] haddr, hwdata, hrdata, rd;
   int          fails = 0, cmp_count = 0, gf = 0, ov_cnt = 0;
   logic        cs_on = 1'b0;

   // Short hold times keep recovery within a few frames
   srx_error_flags #(.HOLD0_US(2), .HOLD1_US(4), .HOLD2_US(6), .HOLD3_US(8))
      srx_error_flags_i (.hsize(3'b010), .hready(hreadyout), .hresp(), .*);
   srx_tx_model srx_tx_model_i (.*);
   // Output strobes seen, one per subframe even while muted
   always @(posedge hclk)
      if (out_valid === 1'b1)
         ov_cnt <= ov_cnt + 1;

   // 25 MHz clock
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   // Counts, then the single verdict
   task automatic give_verdict;
      $display("Compares %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Bounded wait for hready; a stuck bus ends the run
   task automatic wait_rdy;
      int n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            fails++;
            give_verdict;
         end
         @(posedge hclk);
      end
   endtask
   // Single word transfer; read data lands in rd
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      {hsel, htrans, hwrite} <= {1'b1, 2'b10, w};
      haddr <= {24'h000000, a};
      wait_rdy;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
   endtask
   // Frames from a running count, so B stays 192 frames apart
   task automatic frames(input int n, input logic p);
      repeat (n) begin
         // With cs_on, cs bit 1 (non-audio) and bit 3 (50/15 emphasis)
         srx_tx_model_i.sub(1'b1, gf % 192 == 0, p,
                            cs_on && (gf % 192 == 1 || gf % 192 == 3),
                            24'h100000 + 24'(gf));
         srx_tx_model_i.sub(1'b0, 1'b0, p, 1'b0, 24'h200000 + 24'(gf));
         gf++;
      end
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      `CHK("err_flag", 1'b1, error_flag_pin)
      `CHK("irq_n", 1'b1, irq_n)
      `CHK("fs_flag", 1'b0, fs_flag_pin)
      `CHK("indicator", 1'b0, indicator_pin)
      ahb(1'b1, A_CTRL, 32'h00000200);
      ahb(1'b0, A_CTRL, 32'h00000000);
      `CHK("ctrl", 32'h00000200, rd)
      ahb(1'b0, 8'h20, 32'h00000000);
      `CHK("unmapped", 32'h00000000, rd)
      $display("test reset done");
   endtask
   task automatic t_lock;
      frames(400, 1'b0);
      `CHK("err_flag", 1'b0, error_flag_pin)
      `CHK("data", 24'h200000 + 24'(gf - 1), out_data)
      `CHK("out_left", 1'b0, out_left)
      `CHK("out_valid", 800, ov_cnt)
      ahb(1'b0, A_STAT, 32'h00000000);
      `CHK("lock_err", 1'b0, rd[1])
      $display("test lock done");
   endtask
   task automatic t_parity;
      srx_tx_model_i.sub(1'b1, 1'b0, 1'b1, 1'b0, 24'hABCDEF);
      `CHK("subst", 24'h100000 + 24'(gf - 1), out_data)
      srx_tx_model_i.sub(1'b0, 1'b0, 1'b0, 1'b0, 24'h200000 + 24'(gf));
      gf++;
      `CHK("short_run", 1'b0, error_flag_pin)
      frames(6, 1'b1);
      `CHK("long_run", 1'b1, error_flag_pin)
      `CHK("mute", 24'h000000, out_data)
      frames(20, 1'b0);
      `CHK("released", 1'b0, error_flag_pin)
      `CHK("resume", 24'h200000 + 24'(gf - 1), out_data)
      // Parity format bit on: a single bad left subframe shows on the flag
      ahb(1'b1, A_CTRL, 32'h00000240);
      srx_tx_model_i.sub(1'b1, 1'b0, 1'b1, 1'b0, 24'h100000 + 24'(gf));
      `CHK("short_flag", 1'b1, error_flag_pin)
      srx_tx_model_i.sub(1'b0, 1'b0, 1'b0, 1'b0, 24'h200000 + 24'(gf));
      gf++;
      $display("test parity done");
   endtask
   // Non-audio stream with emphasis, burst sync, then non-PCM as error
   task automatic t_nonpcm;
      ahb(1'b1, A_CTRL, 32'h00000204);
      cs_on = 1'b1;
      frames(160, 1'b0);
      `CHK("indicator", 1'b1, indicator_pin)
      `CHK("emphasis", 1'b1, fs_flag_pin)
      srx_tx_model_i.sub(1'b1, 1'b0, 1'b0, 1'b0, 24'hF87200);
      srx_tx_model_i.sub(1'b0, 1'b0, 1'b0, 1'b0, 24'h4E1F00);
      gf++;
      `CHK("irq_n", 1'b0, irq_n)
      ahb(1'b0, A_STAT, 32'h00000000);
      `CHK("iec_sync", 1'b1, rd[5])
      srx_tx_model_i.sub(1'b1, 1'b0, 1'b1, 1'b0, 24'h123456);
      `CHK("raw_nonpcm", 24'h123456, out_data)
      srx_tx_model_i.sub(1'b0, 1'b0, 1'b0, 1'b0, 24'h200000 + 24'(gf));
      gf++;
      ahb(1'b1, A_CTRL, 32'h0000020C);
      frames(2, 1'b0);
      `CHK("np_flag", 1'b1, error_flag_pin)
      `CHK("np_mute", 24'h000000, out_data)
      ahb(1'b1, A_CTRL, 32'h00000200);
      frames(12, 1'b0);
      `CHK("np_release", 1'b0, error_flag_pin)
      $display("test nonpcm done");
   endtask
   task automatic t_unlock;
      biphase_err <= 1'b1;
      @(posedge hclk);
      biphase_err <= 1'b0;
      frames(2, 1'b0);
      `CHK("unlock_flag", 1'b1, error_flag_pin)
      `CHK("unlock_mute", 24'h000000, out_data)
      `CHK("irq_clear", 1'b1, irq_n)
      `CHK("cs_clear", 1'b0, indicator_pin)
      ahb(1'b0, A_STAT, 32'h00000000);
      `CHK("fs_code", 3'h0, rd[10:8])
      `CHK("stat_lock", 1'b1, rd[1])
      $display("test unlock done");
   endtask
   // Reset for 20 cycles, then the scenarios in order
   initial begin
      {hresetn, hsel, hwrite, biphase_err} = '0;
      htrans = 2'b00;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset;
      t_lock;
      t_parity;
      t_nonpcm;
      t_unlock;
      give_verdict;
   end
endmodule // tb_srx_error_flags
